// ==== design/dgcirq_pkg.sv ====
/*
  Constants for the disk-manager general control and interrupt summary block.
  Assumes a single 50 MHz bus clock shared with the microprocessor port.
*/
`default_nettype none
package dgcirq_pkg;
  typedef logic [7:0] dgcirq_byte_t;
  typedef logic [15:0] dgcirq_word_t;
  typedef logic [4:0] dgcirq_group_t;
  typedef logic [2:0] dgcirq_count_t;

  // Register offsets
  localparam dgcirq_byte_t OFS_GENERAL_CONFIG = 8'h00;
  localparam dgcirq_byte_t OFS_IRQ_SUMMARY_ONE = 8'h02;
  localparam dgcirq_byte_t OFS_IRQ_SUMMARY_TWO = 8'h04;
  localparam dgcirq_byte_t OFS_IRQ_ENABLE_ONE = 8'h06;
  localparam dgcirq_byte_t OFS_IRQ_ENABLE_TWO = 8'h08;
  localparam dgcirq_byte_t OFS_BUS_CAPTURE_HIGH = 8'h0a;
  localparam dgcirq_byte_t OFS_BUS_CAPTURE_LOW = 8'h0c;
  localparam dgcirq_byte_t OFS_BUS_CAPTURE_PARITY = 8'h0e;

  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int READY_LSB = 1;
  localparam int READY_MSB = 2;
  localparam int REVISION_LSB = 4;
  localparam int REVISION_MSB = 7;
  localparam int ANY_PENDING_BIT = 7;
  localparam int GROUP_MSB = 4;

  // Revision code, value is arbitrary
  localparam logic [3:0] REVISION_FIELD = 4'h5;

  // Ready control codes and their wait lengths in bus clocks
  localparam logic [1:0] READY_CODE_SIX = 2'h0;
  localparam logic [1:0] READY_CODE_FIVE = 2'h1;
  localparam logic [1:0] READY_CODE_FOUR = 2'h2;
  localparam logic [1:0] READY_CODE_NONE = 2'h3;
  localparam dgcirq_count_t WAIT_SIX = 3'h6;
  localparam dgcirq_count_t WAIT_FIVE = 3'h5;
  localparam dgcirq_count_t WAIT_FOUR = 3'h4;
  localparam dgcirq_count_t WAIT_NONE = 3'h0;
  localparam dgcirq_count_t WAIT_LAST = 3'h1;

  // Reset values
  localparam dgcirq_byte_t BYTE_ZERO = 8'h00;
  localparam dgcirq_word_t WORD_ZERO = 16'h0000;
  localparam dgcirq_group_t GROUP_ZERO = 5'h00;
  localparam logic [1:0] PAIR_ZERO = 2'h0;
  localparam dgcirq_count_t COUNT_ZERO = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } dgcirq_state_e;
endpackage : dgcirq_pkg
`default_nettype wire

// ==== design/dgcirq_top.sv ====
/*
  General control registers of the disk manager: bus port with ready extension,
  configuration with soft disk-manager reset, interrupt summaries and masks, and the
  host-bus capture latch.
  Assumes pins arrive asynchronously; source flags come from logic on CLOCK.
*/
`default_nettype none
module dgcirq_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HW_RESET_N,
  input wire logic ALE,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire dgcirq_pkg::dgcirq_byte_t AD_IN,
  output logic [7:0] AD_OUT,
  output logic AD_OE_N,
  output logic CPU_WAIT_OUT,
  input wire logic CPU_BUFFER_PARITY_FLAG,
  input wire logic HOST_BUFFER_FLAG,
  input wire logic DISK_ERROR_FLAG,
  input wire logic DISK_BUFFER_FLAG,
  input wire logic DISK_SEQUENCER_FLAG,
  input wire dgcirq_pkg::dgcirq_word_t HOST_DATA_BUS,
  input wire logic HOST_PARITY_LOW,
  input wire logic HOST_PARITY_HIGH,
  output logic IRQ_PIN_ONE,
  output logic IRQ_PIN_TWO,
  output logic DM_RESET
);
  import dgcirq_pkg::*;

  // Pin synchronisers
  logic ale_s1, ale_s2, cs_n_s1, cs_n_s2, hw_n_s1, hw_n_s2;
  logic rd_n_s1, rd_n_s2, rd_n_s3, wr_n_s1, wr_n_s2, wr_n_s3;
  dgcirq_byte_t ad_s1, ad_s2;
  logic [17:0] bus_s1, bus_s2;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ale_s1 <= 1'b0;
      ale_s2 <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      hw_n_s1 <= 1'b0;
      hw_n_s2 <= 1'b0;
      rd_n_s1 <= 1'b1;
      rd_n_s2 <= 1'b1;
      rd_n_s3 <= 1'b1;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
      wr_n_s3 <= 1'b1;
      ad_s1 <= BYTE_ZERO;
      ad_s2 <= BYTE_ZERO;
      bus_s1 <= {PAIR_ZERO, WORD_ZERO};
      bus_s2 <= {PAIR_ZERO, WORD_ZERO};
    end else begin
      ale_s1 <= ALE;
      ale_s2 <= ale_s1;
      cs_n_s1 <= CHIP_SELECT_N;
      cs_n_s2 <= cs_n_s1;
      hw_n_s1 <= HW_RESET_N;
      hw_n_s2 <= hw_n_s1;
      rd_n_s1 <= READ_STROBE_N;
      rd_n_s2 <= rd_n_s1;
      rd_n_s3 <= rd_n_s2;
      wr_n_s1 <= WRITE_STROBE_N;
      wr_n_s2 <= wr_n_s1;
      wr_n_s3 <= wr_n_s2;
      ad_s1 <= AD_IN;
      ad_s2 <= ad_s1;
      bus_s1 <= {HOST_PARITY_LOW, HOST_PARITY_HIGH, HOST_DATA_BUS};
      bus_s2 <= bus_s1;
    end
  end

  logic rd_fall, wr_fall;
  assign rd_fall = rd_n_s3 & ~rd_n_s2;
  assign wr_fall = wr_n_s3 & ~wr_n_s2;

  // Address phase
  dgcirq_byte_t addr_reg;
  logic sel_reg;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      addr_reg <= BYTE_ZERO;
      sel_reg <= 1'b0;
    end else if (ale_s2) begin
      addr_reg <= ad_s2;
      sel_reg <= ~cs_n_s2;
    end
  end

  // Configuration and reset
  logic [1:0] ready_code_reg;
  logic soft_reset_reg;
  logic hw_reset_active;
  logic dm_reset_next;
  logic commit;
  logic write_now;
  logic is_write_reg;
  assign hw_reset_active = RST | ~hw_n_s2;
  // Reset from pin or soft bit
  assign dm_reset_next = hw_reset_active | soft_reset_reg;

  always_ff @(posedge CLOCK) begin
    if (hw_reset_active) begin
      ready_code_reg <= READY_CODE_SIX;
      soft_reset_reg <= 1'b0;
    // Soft bit changes by write or hardware reset only
    end else if (commit && write_now && addr_reg == OFS_GENERAL_CONFIG) begin
      ready_code_reg <= ad_s2[READY_MSB:READY_LSB];
      soft_reset_reg <= ad_s2[SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    DM_RESET <= dm_reset_next;
  end

  // Ready extension
  dgcirq_state_e state_reg;
  dgcirq_count_t count_reg;
  dgcirq_count_t wait_len;
  logic start;
  assign start = sel_reg & (rd_fall | wr_fall);

  always_comb begin
    unique case (ready_code_reg)
      READY_CODE_SIX: wait_len = WAIT_SIX;
      READY_CODE_FIVE: wait_len = WAIT_FIVE;
      READY_CODE_FOUR: wait_len = WAIT_FOUR;
      READY_CODE_NONE: wait_len = WAIT_NONE;
    endcase
  end

  assign commit = (state_reg == ST_IDLE && start && wait_len == WAIT_NONE) ||
                  (state_reg == ST_WAIT && count_reg == WAIT_LAST);
  // Code three commits at start, before the access kind is stored
  assign write_now = (state_reg == ST_IDLE) ? wr_fall : is_write_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      count_reg <= COUNT_ZERO;
      CPU_WAIT_OUT <= 1'b0;
      is_write_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            is_write_reg <= wr_fall;
            count_reg <= wait_len;
            if (wait_len == WAIT_NONE) begin
              state_reg <= ST_DONE;
            end else begin
              CPU_WAIT_OUT <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (count_reg == WAIT_LAST) begin
            CPU_WAIT_OUT <= 1'b0;
            state_reg <= ST_DONE;
          end else begin
            count_reg <= count_reg - WAIT_LAST;
          end
        end
        ST_DONE: begin
          if (rd_n_s2 && wr_n_s2) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Interrupt masks, cleared by disk-manager reset
  dgcirq_group_t enable_one_reg, enable_two_reg, flags;
  assign flags = {CPU_BUFFER_PARITY_FLAG, HOST_BUFFER_FLAG, DISK_ERROR_FLAG,
                  DISK_BUFFER_FLAG, DISK_SEQUENCER_FLAG};

  always_ff @(posedge CLOCK) begin
    if (dm_reset_next) begin
      enable_one_reg <= GROUP_ZERO;
      enable_two_reg <= GROUP_ZERO;
    end else if (commit && write_now) begin
      if (addr_reg == OFS_IRQ_ENABLE_ONE) begin
        enable_one_reg <= ad_s2[GROUP_MSB:0];
      end
      if (addr_reg == OFS_IRQ_ENABLE_TWO) begin
        enable_two_reg <= ad_s2[GROUP_MSB:0];
      end
    end
  end

  // Summaries and pins
  dgcirq_group_t summary_one_reg, summary_two_reg;
  always_ff @(posedge CLOCK) begin
    if (dm_reset_next) begin
      summary_one_reg <= GROUP_ZERO;
      summary_two_reg <= GROUP_ZERO;
      IRQ_PIN_ONE <= 1'b0;
      IRQ_PIN_TWO <= 1'b0;
    end else begin
      summary_one_reg <= flags & enable_one_reg;
      summary_two_reg <= flags & enable_two_reg;
      IRQ_PIN_ONE <= |(flags & enable_one_reg);
      IRQ_PIN_TWO <= |(flags & enable_two_reg);
    end
  end

  // Host bus capture
  dgcirq_word_t capture_data_reg;
  logic [1:0] capture_parity_reg;
  always_ff @(posedge CLOCK) begin
    if (!hw_n_s2) begin
      capture_data_reg <= bus_s2[15:0];
      capture_parity_reg <= bus_s2[17:16];
    end
  end

  // Read path
  dgcirq_byte_t read_mux;
  always_comb begin
    read_mux = BYTE_ZERO;
    unique case (addr_reg)
      OFS_GENERAL_CONFIG: read_mux = {REVISION_FIELD, 1'b0, ready_code_reg, soft_reset_reg};
      OFS_IRQ_SUMMARY_ONE: read_mux = {IRQ_PIN_ONE, 2'h0, summary_one_reg};
      OFS_IRQ_SUMMARY_TWO: read_mux = {IRQ_PIN_TWO, 2'h0, summary_two_reg};
      OFS_IRQ_ENABLE_ONE: read_mux = {3'h0, enable_one_reg};
      OFS_IRQ_ENABLE_TWO: read_mux = {3'h0, enable_two_reg};
      OFS_BUS_CAPTURE_HIGH: read_mux = capture_data_reg[15:8];
      OFS_BUS_CAPTURE_LOW: read_mux = capture_data_reg[7:0];
      OFS_BUS_CAPTURE_PARITY: read_mux = {6'h00, capture_parity_reg};
      default: read_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      AD_OUT <= BYTE_ZERO;
      AD_OE_N <= 1'b1;
    end else begin
      AD_OUT <= read_mux;
      AD_OE_N <= ~(sel_reg & ~rd_n_s2);
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_wait_begin(logic [1:0] code);
    $rose(CPU_WAIT_OUT) && ready_code_reg == code;
  endsequence

  property p_wait_six;
    s_wait_begin(READY_CODE_SIX) |-> CPU_WAIT_OUT [*6] ##1 !CPU_WAIT_OUT;
  endproperty
  a_wait_six: assert property (p_wait_six) else $error("wait not six clocks");

  property p_wait_five;
    s_wait_begin(READY_CODE_FIVE) |-> CPU_WAIT_OUT [*5] ##1 !CPU_WAIT_OUT;
  endproperty
  a_wait_five: assert property (p_wait_five) else $error("wait not five clocks");

  property p_wait_four;
    s_wait_begin(READY_CODE_FOUR) |-> CPU_WAIT_OUT [*4] ##1 !CPU_WAIT_OUT;
  endproperty
  a_wait_four: assert property (p_wait_four) else $error("wait not four clocks");

  property p_release;
    $rose(CPU_WAIT_OUT) |-> ##[4:6] !CPU_WAIT_OUT;
  endproperty
  a_release: assert property (p_release) else $error("wait release late");

  property p_no_wait;
    (state_reg == ST_IDLE && start && ready_code_reg == READY_CODE_NONE) |=> !CPU_WAIT_OUT [*2];
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait with code three");

  property p_revision;
    addr_reg == OFS_GENERAL_CONFIG |-> read_mux[REVISION_MSB:REVISION_LSB] == REVISION_FIELD;
  endproperty
  a_revision: assert property (p_revision) else $error("revision field wrong");

  property p_soft_reset;
    soft_reset_reg |=> DM_RESET && IRQ_PIN_ONE == 1'b0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  property p_soft_hold;
    ($fell(soft_reset_reg) && hw_n_s2) |-> $past(commit);
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft bit cleared itself");

  property p_summary;
    !$past(dm_reset_next) |-> summary_one_reg == $past(flags & enable_one_reg);
  endproperty
  a_summary: assert property (p_summary) else $error("summary one mismatch");

  property p_pin_tracks;
    IRQ_PIN_ONE == (|summary_one_reg) && IRQ_PIN_TWO == (|summary_two_reg);
  endproperty
  a_pin_tracks: assert property (p_pin_tracks) else $error("pin differs from summary");

  property p_capture_hold;
    (hw_n_s2 && $past(hw_n_s2)) |-> $stable(capture_data_reg);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture changed");
endmodule : dgcirq_top
`default_nettype wire

// ==== testbench/dgcirq_cpu_model.sv ====
/*
  Microprocessor model: multiplexed-bus register cycles with wait extension.
  Assumes it shares the bus clock with the block.
*/
`default_nettype none
module dgcirq_cpu_model (
  input wire logic clk,
  output var logic ale,
  output var logic cs_n,
  output var logic rd_n,
  output var logic wr_n,
  output var logic [7:0] ad,
  input wire logic wait_in,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ad = 8'h00;
  end
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] data, output int len);
    len = 0;
    @(posedge clk);
    ale <= 1'b1;
    cs_n <= 1'b0;
    ad <= a;
    repeat (3) @(posedge clk);
    ale <= 1'b0;
    ad <= wr ? wd : ~a;
    @(posedge clk);
    rd_n <= wr;
    wr_n <= !wr;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wait_in) len++;
      else if (len > 0 || n > 8) break;
    end
    data = rdata;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    ad <= ~ad;
    repeat (5) @(posedge clk);
  endtask : access
endmodule : dgcirq_cpu_model
`default_nettype wire

// ==== testbench/disk_general_control_irq_tb.sv ====
/*
  Self-checking bench for the general control and interrupt summary block.
  Assumes the processor model drives the bus; flags and capture pins from here.
*/
`default_nettype none
module disk_general_control_irq_tb;
  import dgcirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hw_n, ale, cs_n, rd_n, wr_n, wait_o, oe_n, pin1, pin2, dm_rst;
  logic par_lo, par_hi;
  logic [7:0] cpu_ad, ad_out, rd;
  dgcirq_byte_t ad_wire;
  dgcirq_group_t flags;
  dgcirq_word_t hbus;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int len;
  assign ad_wire = (oe_n === 1'b0) ? ad_out : cpu_ad;
  dgcirq_top DUT (.CLOCK(clk), .RST(rst), .HW_RESET_N(hw_n), .ALE(ale),
    .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .AD_IN(ad_wire),
    .AD_OUT(ad_out), .AD_OE_N(oe_n), .CPU_WAIT_OUT(wait_o),
    .CPU_BUFFER_PARITY_FLAG(flags[4]), .HOST_BUFFER_FLAG(flags[3]),
    .DISK_ERROR_FLAG(flags[2]), .DISK_BUFFER_FLAG(flags[1]),
    .DISK_SEQUENCER_FLAG(flags[0]), .HOST_DATA_BUS(hbus), .HOST_PARITY_LOW(par_lo),
    .HOST_PARITY_HIGH(par_hi), .IRQ_PIN_ONE(pin1), .IRQ_PIN_TWO(pin2), .DM_RESET(dm_rst));
  dgcirq_cpu_model cpu (.clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .ad(cpu_ad), .wait_in(wait_o), .rdata(ad_wire));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic check1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check1
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    cpu.access(1'b1, a, d, x, len);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    cpu.access(1'b0, a, 8'h00, rd, len);
  endtask : reg_rd
  task automatic t_ready;
    int exp_len [4] = '{6, 5, 4, 0};
    reg_rd(OFS_GENERAL_CONFIG);
    check8("config", {REVISION_FIELD, 4'h0}, rd);
    check8("wait clocks", 8'h06, 8'(len));
    check1("drive off", 1'b1, oe_n);
    for (int i = 0; i < 4; i++) begin
      reg_wr(OFS_GENERAL_CONFIG, {4'ha, 1'b0, 2'(i), 1'b0});
      reg_rd(OFS_GENERAL_CONFIG);
      check8("config", {REVISION_FIELD, 1'b0, 2'(i), 1'b0}, rd);
      check8("wait clocks", 8'(exp_len[i]), 8'(len));
    end
    reg_wr(OFS_GENERAL_CONFIG, 8'h00);
    $display("t_ready done");
  endtask : t_ready
  task automatic t_irq;
    for (int i = 0; i < 5; i++) begin
      flags <= 5'h01 << i;
      reg_wr(OFS_IRQ_ENABLE_ONE, 8'h01 << i);
      reg_wr(OFS_IRQ_ENABLE_TWO, {3'h0, ~(5'h01 << i)});
      reg_rd(OFS_IRQ_SUMMARY_ONE);
      check8("summary one", 8'h80 | (8'h01 << i), rd);
      reg_rd(OFS_IRQ_SUMMARY_TWO);
      check8("summary two", 8'h00, rd);
      check1("pin one", 1'b1, pin1);
      check1("pin two", 1'b0, pin2);
      reg_wr(OFS_IRQ_ENABLE_ONE, 8'h00);
      reg_rd(OFS_IRQ_SUMMARY_ONE);
      check8("summary one masked", 8'h00, rd);
      check1("pin one masked", 1'b0, pin1);
    end
    flags <= 5'h1f;
    reg_rd(OFS_IRQ_SUMMARY_TWO);
    check8("summary two", 8'h8f, rd);
    check1("pin two", 1'b1, pin2);
    reg_rd(OFS_IRQ_ENABLE_TWO);
    check8("enable two", 8'h0f, rd);
    flags <= 5'h00;
    reg_rd(OFS_IRQ_SUMMARY_TWO);
    check8("summary two cleared", 8'h00, rd);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_soft;
    reg_wr(OFS_IRQ_ENABLE_ONE, 8'h1f);
    flags <= 5'h1f;
    reg_wr(OFS_GENERAL_CONFIG, 8'h01);
    check1("dm reset", 1'b1, dm_rst);
    reg_rd(OFS_GENERAL_CONFIG);
    check8("config soft", {REVISION_FIELD, 4'h1}, rd);
    reg_rd(OFS_IRQ_ENABLE_ONE);
    check8("enable one soft", 8'h00, rd);
    check1("pin one soft", 1'b0, pin1);
    reg_wr(OFS_GENERAL_CONFIG, 8'h00);
    check1("dm reset", 1'b0, dm_rst);
    flags <= 5'h00;
    $display("t_soft done");
  endtask : t_soft
  task automatic t_capture;
    hbus <= 16'ha5c3;
    par_lo <= 1'b1;
    par_hi <= 1'b0;
    hw_n <= 1'b0;
    repeat (8) @(posedge clk);
    hw_n <= 1'b1;
    repeat (4) @(posedge clk);
    hbus <= 16'h3c5a;
    par_lo <= 1'b0;
    par_hi <= 1'b1;
    reg_rd(OFS_BUS_CAPTURE_HIGH);
    check8("capture high", 8'ha5, rd);
    reg_rd(OFS_BUS_CAPTURE_PARITY);
    check8("capture parity", 8'h02, rd);
    reg_wr(OFS_BUS_CAPTURE_LOW, 8'hff);
    reg_rd(OFS_BUS_CAPTURE_LOW);
    check8("capture low", 8'hc3, rd);
    reg_rd(8'h10);
    check8("unmapped", 8'h00, rd);
    check1("dm reset", 1'b0, dm_rst);
    $display("t_capture done");
  endtask : t_capture
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("BAD cycle limit expected 20000 seen %0d", cycles);
      print_verdict;
    end
  end
  initial begin
    rst = 1'b1;
    hw_n = 1'b1;
    flags = 5'h00;
    hbus = 16'h0000;
    par_lo = 1'b0;
    par_hi = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_ready;
    t_irq;
    t_soft;
    t_capture;
    print_verdict;
  end
endmodule : disk_general_control_irq_tb
`default_nettype wire
